// ==== rtl/smc_pkg.sv ====
// package for the sleep mode controller: register map, fields, states, counts
// assumes a single 200 MHz clock and a 32-bit axi4-lite register bus
package smc_pkg;
   // clock rate
   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam real         CLK_PERIOD_NS  = 5.0;

   // register byte offsets
   localparam logic [3:0] CTRL_OFFS      = 4'h0;  // core_control_register
   localparam logic [3:0] STAT_OFFS      = 4'h4;  // state readback
   localparam logic [7:0] CTRL_RESET     = 8'h00;

   // core_control_register field positions
   localparam int unsigned PULLUP_DIS_BIT = 7;
   localparam int unsigned SM_HIGH_BIT    = 6;
   localparam int unsigned SLEEP_EN_BIT   = 5;
   localparam int unsigned SM_LOW_BIT     = 4;
   localparam int unsigned ISC1_LSB       = 2;
   localparam int unsigned ISC0_LSB       = 0;

   // mode select codes (high, low)
   localparam logic [1:0] MODE_IDLE      = 2'h0;
   localparam logic [1:0] MODE_PDOWN_A   = 2'h1;
   localparam logic [1:0] MODE_STBY      = 2'h2;
   localparam logic [1:0] MODE_PDOWN_B   = 2'h3;

   // interrupt sense code for low-level detection
   localparam logic [1:0] ISC_LEVEL_LOW  = 2'h0;

   // brown-out fuse code meaning disabled
   localparam logic [2:0] BOD_FUSE_OFF   = 3'h7;

   // wake timing in clock cycles
   localparam logic [7:0] STBY_WAKE_CYC  = 8'h06;
   localparam logic [7:0] PD_WAKE_CYC    = 8'h06;
   localparam logic [7:0] HALT_CYC       = 8'h04;

   // axi responses
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // controller states, one-hot
   typedef enum logic [5:0] {
      ST_RUN   = 6'h01,
      ST_IDLE  = 6'h02,
      ST_PDOWN = 6'h04,
      ST_STBY  = 6'h08,
      ST_WAKE  = 6'h10,
      ST_HALT  = 6'h20
   } smc_state_t;
endpackage

// ==== rtl/smc_top.sv ====
// sleep mode controller: decides sleep entry, clock gating, wake and halt
// assumes the core pulses sleep_instr for one cycle and the wake and reset
// requests come from logic on ref_clk; only the irq zero pin is asynchronous
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module smc_top
   import smc_pkg::*;
#(
   parameter logic [7:0] PD_STARTUP_CYC = PD_WAKE_CYC,  // power-down start-up
   parameter logic [3:0] XTAL_FUSE_MIN  = 4'h8          // first crystal code
) (
   input  wire logic        ref_clk,           // system clock
   input  wire logic        srst,              // sync reset, high
   // axi4-lite slave
   input  wire logic [3:0]  s_axi_awaddr,      // write address
   input  wire logic        s_axi_awvalid,     // write address valid
   output logic             s_axi_awready,     // write address ready
   input  wire logic [31:0] s_axi_wdata,       // write data
   input  wire logic [3:0]  s_axi_wstrb,       // write strobes
   input  wire logic        s_axi_wvalid,      // write data valid
   output logic             s_axi_wready,      // write data ready
   output logic [1:0]       s_axi_bresp,       // write response
   output logic             s_axi_bvalid,      // write response valid
   input  wire logic        s_axi_bready,      // write response ready
   input  wire logic [3:0]  s_axi_araddr,      // read address
   input  wire logic        s_axi_arvalid,     // read address valid
   output logic             s_axi_arready,     // read address ready
   output logic [31:0]      s_axi_rdata,       // read data
   output logic [1:0]       s_axi_rresp,       // read response
   output logic             s_axi_rvalid,      // read data valid
   input  wire logic        s_axi_rready,      // read data ready
   // core and interrupt system
   input  wire logic        sleep_instr,       // sleep executed, pulse
   input  wire logic        irq_pending,       // any enabled interrupt
   input  wire logic        serial_start_irq,  // serial start condition
   input  wire logic        pin_change_irq,    // pin change interrupt
   input  wire logic        wdt_irq,           // watchdog interrupt
   input  wire logic        eirq0_enable,      // external_interrupt_zero enabled
   input  wire logic        eirq0_pin,         // external_interrupt_zero pin
   input  wire logic        reset_req,         // ext, wdt or bod reset
   // fuses and peripheral settings
   input  wire logic [3:0]  clock_source_fuses,   // clock source select
   input  wire logic [2:0]  brownout_level_fuses, // bod level select
   input  wire logic        wdt_enable,        // watchdog enabled
   input  wire logic        acmp_enable,       // comparator_disable_bit low
   input  wire logic        acmp_uses_vref,    // comparator on internal ref
   // clock and power controls
   output logic             core_clk_en,       // core_clock enable
   output logic             flash_clk_en,      // program_memory_clock enable
   output logic             io_clk_en,         // peripheral_io_clock enable
   output logic             osc_en,            // oscillator enable
   output logic             core_halt,         // core held, state kept
   output logic             resume_pulse,      // resume after sleep
   output logic             reset_vector_req,  // restart at reset vector
   output logic             acmp_off,          // comparator forced off
   output logic             vref_en,           // internal reference power
   output logic             bod_active,        // brown-out detector on
   output logic             wdt_run,           // watchdog clock on
   output logic             din_buf_en,        // general input buffers
   output logic             wake_buf_en        // wake pin input buffers
);

   // register and state storage
   logic [7:0]  ctrl_r;
   smc_state_t  state_r, state_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic        eirq0_s1_r, eirq0_s2_r, eirq0_s3_r, eirq0_lvl_r;
   logic        core_clk_en_r, flash_clk_en_r, io_clk_en_r, osc_en_r;
   logic        core_halt_r, resume_r, rstvec_r, acmp_off_r, vref_en_r;
   logic        bod_active_r, wdt_run_r, din_buf_en_r, wake_buf_en_r;
   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic        aw_held_r, w_held_r;
   logic [3:0]  awaddr_r;
   logic [7:0]  wbyte_r;
   logic        wstrb0_r;

   // control field decode
   wire logic [1:0] mode_sel   = {ctrl_r[SM_HIGH_BIT], ctrl_r[SM_LOW_BIT]};
   wire logic       sleep_en   = ctrl_r[SLEEP_EN_BIT];
   wire logic [1:0] isc0       = ctrl_r[ISC0_LSB +: 2];
   wire logic       xtal_sel   = (clock_source_fuses >= XTAL_FUSE_MIN);
   wire logic       sleep_go   = sleep_instr && sleep_en;
   wire logic       to_idle    = (mode_sel == MODE_IDLE);
   wire logic       to_stby    = (mode_sel == MODE_STBY) && xtal_sel;
   // level-only irq zero wake from deep sleep
   wire logic       eirq0_wake = eirq0_enable && (isc0 == ISC_LEVEL_LOW)
                                 && !eirq0_lvl_r;
   wire logic       deep_wake  = serial_start_irq || pin_change_irq || wdt_irq
                                 || eirq0_wake;
   wire logic       idle_wake  = irq_pending || deep_wake;
   wire logic       asleep     = (state_r == ST_IDLE) || (state_r == ST_PDOWN)
                                 || (state_r == ST_STBY);
   wire logic       deep_nxt   = (state_nxt == ST_PDOWN) || (state_nxt == ST_STBY);
   wire logic       running_nxt = (state_nxt == ST_RUN);

   // irq zero pin: three stages, level accepted once stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         eirq0_s1_r  <= 1'b1;
         eirq0_s2_r  <= 1'b1;
         eirq0_s3_r  <= 1'b1;
         eirq0_lvl_r <= 1'b1;
      end else begin
         eirq0_s1_r <= eirq0_pin;
         eirq0_s2_r <= eirq0_s1_r;
         eirq0_s3_r <= eirq0_s2_r;
         if (eirq0_s2_r == eirq0_s3_r) begin
            eirq0_lvl_r <= eirq0_s3_r;  // a short glitch never reaches here
         end
      end
   end

   // next state and wake counter
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         ST_RUN: begin
            if (sleep_go) begin
               if (to_idle) begin
                  state_nxt = ST_IDLE;
               end else if (to_stby) begin
                  state_nxt = ST_STBY;
               end else begin
                  state_nxt = ST_PDOWN;
               end
            end
         end
         ST_IDLE: begin
            if (reset_req) begin
               state_nxt = ST_RUN;
            end else if (idle_wake) begin
               state_nxt = ST_HALT;
               cnt_nxt   = HALT_CYC - 8'h01;
            end
         end
         ST_PDOWN: begin
            if (reset_req) begin
               state_nxt = ST_RUN;
            end else if (deep_wake) begin
               state_nxt = ST_WAKE;
               cnt_nxt   = PD_STARTUP_CYC - 8'h01;
            end
         end
         ST_STBY: begin
            if (reset_req) begin
               state_nxt = ST_RUN;
            end else if (deep_wake) begin
               state_nxt = ST_WAKE;
               cnt_nxt   = STBY_WAKE_CYC - 8'h01;
            end
         end
         ST_WAKE: begin
            if (reset_req) begin
               state_nxt = ST_RUN;
            end else if (cnt_r == 8'h00) begin
               state_nxt = ST_HALT;
               cnt_nxt   = HALT_CYC - 8'h01;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         ST_HALT: begin
            if (reset_req || (cnt_r == 8'h00)) begin
               state_nxt = ST_RUN;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         default: begin
            state_nxt = ST_RUN;
            cnt_nxt   = 8'h00;
         end
      endcase
   end

   // event pulses for the core
   wire logic resume_nxt = (state_r == ST_HALT) && (cnt_r == 8'h00) && !reset_req;
   wire logic rstvec_nxt = (asleep || (state_r == ST_WAKE) || (state_r == ST_HALT))
                           && reset_req;

   // clock and power controls, computed from the next state so they align
   wire logic core_on_nxt = running_nxt;
   wire logic io_on_nxt   = !deep_nxt;
   wire logic osc_on_nxt  = (state_nxt != ST_PDOWN);
   wire logic bod_on      = (brownout_level_fuses != BOD_FUSE_OFF);
   wire logic acmp_off_nxt = deep_nxt;
   wire logic vref_nxt    = bod_on || (acmp_enable && acmp_uses_vref)
                            || (acmp_enable && !acmp_off_nxt);

   // state and output registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_r        <= ST_RUN;
         cnt_r          <= 8'h00;
         core_clk_en_r  <= 1'b1;
         flash_clk_en_r <= 1'b1;
         io_clk_en_r    <= 1'b1;
         osc_en_r       <= 1'b1;
         core_halt_r    <= 1'b0;
         resume_r       <= 1'b0;
         rstvec_r       <= 1'b0;
         acmp_off_r     <= 1'b0;
         vref_en_r      <= 1'b0;
         bod_active_r   <= 1'b0;
         wdt_run_r      <= 1'b0;
         din_buf_en_r   <= 1'b1;
         wake_buf_en_r  <= 1'b1;
      end else begin
         state_r        <= state_nxt;
         cnt_r          <= cnt_nxt;
         core_clk_en_r  <= core_on_nxt;
         flash_clk_en_r <= core_on_nxt;
         io_clk_en_r    <= io_on_nxt;
         osc_en_r       <= osc_on_nxt;
         core_halt_r    <= !running_nxt;  // halt only, no state is cleared
         resume_r       <= resume_nxt;
         rstvec_r       <= rstvec_nxt;
         acmp_off_r     <= acmp_off_nxt;
         vref_en_r      <= vref_nxt;
         bod_active_r   <= bod_on;
         wdt_run_r      <= wdt_enable;
         din_buf_en_r   <= io_on_nxt;
         wake_buf_en_r  <= 1'b1;  // wake pins always sensed
      end
   end

   // axi write path: address and data taken in either order
   wire logic aw_take  = s_axi_awvalid && awready_r;
   wire logic w_take   = s_axi_wvalid && wready_r;
   wire logic aw_have  = aw_held_r || aw_take;
   wire logic w_have   = w_held_r || w_take;
   wire logic [3:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
   wire logic [7:0] wr_byte = w_held_r ? wbyte_r : s_axi_wdata[7:0];
   wire logic       wr_lane = w_held_r ? wstrb0_r : s_axi_wstrb[0];
   wire logic wr_fire  = aw_have && w_have && !bvalid_r;
   wire logic wr_ctrl  = wr_fire && (wr_addr == CTRL_OFFS);
   wire logic wr_map   = (wr_addr == CTRL_OFFS) || (wr_addr == STAT_OFFS);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 4'h0;
         wbyte_r   <= 8'h00;
         wstrb0_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         ctrl_r    <= CTRL_RESET;
      end else begin
         if (aw_take) begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            wbyte_r  <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_held_r <= 1'b1;
               awready_r <= 1'b0;
            end
            if (w_take) begin
               w_held_r <= 1'b1;
               wready_r <= 1'b0;
            end
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
         if (wr_ctrl && wr_lane) begin
            ctrl_r <= wr_byte;
         end
      end
   end

   // axi read path: one read at a time, unmapped reads answer slverr
   wire logic ar_take = s_axi_arvalid && arready_r;
   wire logic [31:0] stat_word = {23'h000000, eirq0_lvl_r, 2'h0, state_r};
   wire logic [31:0] rd_word = (s_axi_araddr == CTRL_OFFS) ? {24'h000000, ctrl_r} :
                               (s_axi_araddr == STAT_OFFS) ? stat_word : 32'h00000000;
   wire logic rd_map = (s_axi_araddr == CTRL_OFFS) || (s_axi_araddr == STAT_OFFS);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h00000000;
         rresp_r   <= RESP_OKAY;
      end else if (ar_take) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_word;
         rresp_r   <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   // port drive
   assign s_axi_awready    = awready_r;
   assign s_axi_wready     = wready_r;
   assign s_axi_bresp      = bresp_r;
   assign s_axi_bvalid     = bvalid_r;
   assign s_axi_arready    = arready_r;
   assign s_axi_rdata      = rdata_r;
   assign s_axi_rresp      = rresp_r;
   assign s_axi_rvalid     = rvalid_r;
   assign core_clk_en      = core_clk_en_r;
   assign flash_clk_en     = flash_clk_en_r;
   assign io_clk_en        = io_clk_en_r;
   assign osc_en           = osc_en_r;
   assign core_halt        = core_halt_r;
   assign resume_pulse     = resume_r;
   assign reset_vector_req = rstvec_r;
   assign acmp_off         = acmp_off_r;
   assign vref_en          = vref_en_r;
   assign bod_active       = bod_active_r;
   assign wdt_run          = wdt_run_r;
   assign din_buf_en       = din_buf_en_r;
   assign wake_buf_en      = wake_buf_en_r;

   // checks on sleep entry, wake timing and power controls
   property p_nop_sleep;
      @(posedge ref_clk) disable iff (srst)
      (state_r == ST_RUN) && sleep_instr && !sleep_en && !reset_req
         |=> (state_r == ST_RUN) && core_clk_en_r;
   endproperty
   a_nop_sleep: assert property (p_nop_sleep) else $error("sleep without enable gated");

   property p_idle_entry;
      @(posedge ref_clk) disable iff (srst)
      (state_r == ST_RUN) && sleep_go && (mode_sel == MODE_IDLE)
         |=> (state_r == ST_IDLE) && !core_clk_en_r && !flash_clk_en_r && io_clk_en_r
             && osc_en_r;
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

   property p_pdown_entry;
      @(posedge ref_clk) disable iff (srst)
      (state_r == ST_RUN) && sleep_go && ((mode_sel == MODE_PDOWN_A)
         || (mode_sel == MODE_PDOWN_B))
         |=> (state_r == ST_PDOWN) && !osc_en_r && !io_clk_en_r;
   endproperty
   a_pdown_entry: assert property (p_pdown_entry) else $error("power-down entry wrong");

   property p_stby_entry;
      @(posedge ref_clk) disable iff (srst)
      (state_r == ST_RUN) && sleep_go && (mode_sel == MODE_STBY) && xtal_sel
         |=> (state_r == ST_STBY) && osc_en_r && !io_clk_en_r;
   endproperty
   a_stby_entry: assert property (p_stby_entry) else $error("standby entry wrong");

   property p_halt_four;
      @(posedge ref_clk) disable iff (srst || reset_req)
      $rose(state_r == ST_HALT) |-> (state_r == ST_HALT)[*4] ##1
         ((state_r == ST_RUN) && resume_r && core_clk_en_r);
   endproperty
   a_halt_four: assert property (p_halt_four) else $error("halt not four cycles");

   property p_stby_wake;
      @(posedge ref_clk) disable iff (srst || reset_req)
      (state_r == ST_STBY) && deep_wake |=> (state_r == ST_WAKE)[*6] ##1 (state_r == ST_HALT);
   endproperty
   a_stby_wake: assert property (p_stby_wake) else $error("standby wake not six");

   property p_reset_wake;
      @(posedge ref_clk) disable iff (srst)
      asleep && reset_req |=> (state_r == ST_RUN) && rstvec_r && !resume_r;
   endproperty
   a_reset_wake: assert property (p_reset_wake) else $error("reset did not wake");

   property p_edge_eirq0;
      @(posedge ref_clk) disable iff (srst)
      (state_r == ST_PDOWN) && !reset_req && (isc0 != ISC_LEVEL_LOW) && !serial_start_irq
         && !pin_change_irq && !wdt_irq |=> (state_r == ST_PDOWN);
   endproperty
   a_edge_eirq0: assert property (p_edge_eirq0) else $error("edge irq woke deep sleep");

   property p_acmp_deep;
      @(posedge ref_clk) disable iff (srst)
      ((state_r == ST_PDOWN) || (state_r == ST_STBY)) |-> acmp_off_r && !din_buf_en_r
         && wake_buf_en_r;
   endproperty
   a_acmp_deep: assert property (p_acmp_deep) else $error("deep sleep power wrong");

   property p_bod_wdt;
      @(posedge ref_clk) disable iff (srst)
      ##1 (bod_active_r == ($past(brownout_level_fuses) != BOD_FUSE_OFF))
         && (wdt_run_r == $past(wdt_enable));
   endproperty
   a_bod_wdt: assert property (p_bod_wdt) else $error("bod or watchdog gated");

   property p_vref_bod;
      @(posedge ref_clk) disable iff (srst)
      $past(bod_on) && !$past(srst) |-> vref_en_r;
   endproperty
   a_vref_bod: assert property (p_vref_bod) else $error("vref off with bod on");

endmodule

// ==== verification/smc_core_model.sv ====
// core and interrupt model: issues the sleep pulse and holds wake levels
// assumes the bench requests on ref_clk; levels drop on resume or reset
`timescale 1ns/1ps
module smc_core_model (
   input  wire logic       ref_clk,     // clock
   input  wire logic       srst,        // sync reset
   input  wire logic       go_sleep,    // bench asks for a sleep
   input  wire logic [3:0] wake_req,    // irq, serial, pin, wdt requests
   input  wire logic       done,        // resume or reset vector seen
   output logic            sleep_instr, // one-cycle sleep pulse
   output logic [3:0]      wake_src     // held wake levels
);
   // pulse on every other cycle while asked; hold each level until the core is back
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sleep_instr <= 1'b0;
         wake_src    <= 4'h0;
      end else begin
         sleep_instr <= go_sleep & ~sleep_instr;
         wake_src    <= done ? 4'h0 : (wake_src | wake_req);
      end
   end
endmodule

// ==== verification/tb_top.sv ====
// bench for the sleep mode controller: registers, sleep entry, gating, wake
// assumes smc_pkg and smc_top compiled first, core model beside it
`timescale 1ns/1ps
module tb_top;
   import smc_pkg::*;
   localparam logic [3:0] XT = 4'h8;
   logic        ref_clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, go = 0;
   logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, reset_req = 0;
   logic        eirq0_enable = 1, eirq0_pin = 1, wdt_enable = 0, acmp_enable = 0;
   logic        acmp_uses_vref = 0, sleep_instr, dp;
   logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf, wreq = 0;
   logic [3:0]  clock_source_fuses = 0;
   logic [2:0]  brownout_level_fuses = 3'h7;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, m;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        core_clk_en, flash_clk_en, io_clk_en, osc_en, core_halt, resume_pulse;
   logic        reset_vector_req, acmp_off, vref_en, bod_active, wdt_run, din_buf_en;
   logic        wake_buf_en;
   wire         irq_pending, serial_start_irq, pin_change_irq, wdt_irq;
   logic [7:0]  ctl;
   logic [5:0]  st;
   int          bad_count = 0, checks = 0, n, k, e;
   always #2.5 ref_clk = ~ref_clk;
   smc_top #(.XTAL_FUSE_MIN(XT)) uut (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sleep_instr, .irq_pending, .serial_start_irq, .pin_change_irq, .wdt_irq,
      .eirq0_enable, .eirq0_pin, .reset_req, .clock_source_fuses, .brownout_level_fuses,
      .wdt_enable, .acmp_enable, .acmp_uses_vref, .core_clk_en, .flash_clk_en,
      .io_clk_en, .osc_en, .core_halt, .resume_pulse, .reset_vector_req, .acmp_off,
      .vref_en, .bod_active, .wdt_run, .din_buf_en, .wake_buf_en);
   smc_core_model core (.ref_clk, .srst, .go_sleep(go), .wake_req(wreq),
      .done(resume_pulse | reset_vector_req), .sleep_instr,
      .wake_src({irq_pending, serial_start_irq, pin_change_irq, wdt_irq}));
   // verdict and comparison helpers
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic to_err();
      bad_count++;
      final_report();
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // axi4-lite master cycles, each wait bounded
   task automatic axw(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      int c;
      c = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge ref_clk);
         c++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         if (c > 40) to_err();
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge ref_clk);
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int c;
      c = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge ref_clk);
         c++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         if (c > 40) to_err();
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      @(posedge ref_clk);
   endtask
   task automatic sleep_go();
      go <= 1;
      @(posedge ref_clk);
      go <= 0;
      repeat (4) @(posedge ref_clk);
   endtask
   // main sequence: reset values, refusals, every mode, wake timing, reset wake
   initial begin
      void'($urandom(64661));
      repeat (8) @(posedge ref_clk);
      srst <= 0;
      @(posedge ref_clk);
      axr(CTRL_OFFS, rd, rsp);
      chk("ctrl_reset", rd, {24'h0, CTRL_RESET});
      chk("rd_okay", rsp, RESP_OKAY);
      axr(4'h8, rd, rsp);
      chk("rd_unmapped", rsp, RESP_SLVERR);
      chk("rd_unmapped_data", rd, 32'h0);
      axw(4'hc, 8'hff, rsp);
      chk("wr_unmapped", rsp, RESP_SLVERR);
      sleep_go();
      chk("nop_core_en", core_clk_en, 1);
      for (int i = 0; i < 10; i++) begin
         m = (i < 4) ? 2'(i) : (i == 9) ? 2'h1 : (i == 8) ? 2'h2 : 2'($urandom);
         k = (i == 9) ? 3 : int'($urandom % 3);
         clock_source_fuses <= (i == 2) ? XT : (i == 8) ? 4'h0 : 4'($urandom);
         brownout_level_fuses <= 3'($urandom);
         {wdt_enable, acmp_enable, acmp_uses_vref} <= 3'($urandom);
         ctl = {1'b0, m[1], 1'b1, m[0], 2'h0, (k == 3) ? 2'h0 : 2'h1};
         axw(CTRL_OFFS, ctl, rsp);
         chk("wr_okay", rsp, RESP_OKAY);
         st = (m == MODE_IDLE) ? ST_IDLE : (m == MODE_STBY && clock_source_fuses >= XT)
            ? ST_STBY : ST_PDOWN;
         dp = (st != ST_IDLE);
         sleep_go();
         chk("core_en", core_clk_en, 0);
         chk("flash_en", flash_clk_en, 0);
         chk("io_en", io_clk_en, !dp);
         chk("osc_en", osc_en, st != ST_PDOWN);
         chk("acmp_off", acmp_off, dp);
         chk("din_buf", din_buf_en, !dp);
         chk("wake_buf", wake_buf_en, 1);
         chk("bod_on", bod_active, brownout_level_fuses != BOD_FUSE_OFF);
         chk("wdt_on", wdt_run, wdt_enable);
         chk("vref", vref_en, (brownout_level_fuses != BOD_FUSE_OFF)
            | (acmp_enable & (acmp_uses_vref | !dp)));
         axr(STAT_OFFS, rd, rsp);
         chk("state", rd[5:0], st);
         if (dp) begin
            wreq <= 4'h8;
            eirq0_pin <= 0;
            eirq0_enable <= (k != 3);
            repeat (12) @(posedge ref_clk);
            wreq <= 4'h0;
            eirq0_pin <= 1;
            axr(STAT_OFFS, rd, rsp);
            chk("no_wake", rd[5:0], st);
         end
         eirq0_enable <= 1;
         if (k == 3) eirq0_pin <= 0;
         else wreq <= dp ? 4'h1 << k : 4'h8;
         @(posedge ref_clk);
         wreq <= 4'h0;
         n = 1;
         do begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > 60) to_err();
         end while (resume_pulse !== 1'b1);
         e = dp ? ((st == ST_STBY) ? STBY_WAKE_CYC : PD_WAKE_CYC) + HALT_CYC + 2
            : HALT_CYC + 2;
         if (k != 3) chk("wake_cycles", n, e);
         chk("core_run", {core_clk_en, core_halt}, 2'h2);
         @(posedge ref_clk);
         eirq0_pin <= 1;
         axr(CTRL_OFFS, rd, rsp);
         chk("ctrl_kept", rd, {24'h0, ctl});
      end
      axw(CTRL_OFFS, 8'h30, rsp);
      sleep_go();
      reset_req <= 1;
      @(posedge ref_clk);
      reset_req <= 0;
      #1;
      chk("rst_vector", {reset_vector_req, core_clk_en}, 2'h3);
      @(posedge ref_clk);
      final_report();
   end
endmodule
